//--- include/iad_pkg.sv
package iad_pkg;

	localparam int DW = 16;
	localparam int SELW = 4;
	localparam int UAW = 9;
	localparam int RAW = 4;

	// default decode values of processor-internal addresses; each but SCRATCH_MASK is a module parameter
	localparam logic [15:0] DEF_STATUS_ADDR = 16'hFFFE;
	localparam logic [15:0] DEF_LIMIT_ADDR = 16'hFFFA;
	localparam logic [15:0] DEF_SCRATCH_BASE = 16'hFFC0;
	localparam logic [15:0] DEF_SWITCH_ADDR = 16'hFF78;
	localparam logic [15:0] SCRATCH_MASK = 16'hFFF0;

	// bus address latch fields, data nibble top bit
	localparam int BA_TEST_HI = 6;
	localparam int BA_TEST_LO = 3;
	localparam int BA_SEG_HI = 7;
	localparam int BA_SEG_LO = 5;
	localparam int BA_TOP_HI = 15;
	localparam int BA_TOP_LO = 8;
	localparam int D_NIB_HI = 3;

	// register port map
	localparam logic [RAW-1:0] REG_CTRL = 4'h0;
	localparam logic [RAW-1:0] REG_STAT = 4'h4;
	localparam logic [RAW-1:0] REG_YLIM = 4'h8;
	localparam logic [RAW-1:0] REG_RLIM = 4'hC;

	localparam int CTRL_LIMIT_EN = 0;
	localparam int CTRL_CHECK_EN = 1;
	localparam logic [15:0] CTRL_RESET = 16'h0002;
	localparam logic [15:0] YLIM_RESET = 16'h0100;
	localparam logic [15:0] RLIM_RESET = 16'h00E0;

	typedef struct packed {
		logic [RAW-1:0] addr;
		logic [DW-1:0] wdata;
		logic we;
		logic re;
	} iad_regreq_t;

	typedef struct packed {
		logic status_word;
		logic stack_limit;
		logic scratch;
		logic switches;
	} iad_hits_t;

	typedef enum logic [1:0] {
		SRC_IMMEDIATE,
		SRC_INSTR_SRC,
		SRC_INSTR_DST,
		SRC_BUS_ADDR
	} iad_selsrc_t;

endpackage

//--- rtl/iad_decode.sv
`timescale 1ns/1ps
module iad_decode import iad_pkg::*; #(
	parameter logic [15:0] STATUS_ADDR = DEF_STATUS_ADDR,
	parameter logic [15:0] LIMIT_ADDR = DEF_LIMIT_ADDR,
	parameter logic [15:0] SCRATCH_BASE = DEF_SCRATCH_BASE,
	parameter logic [15:0] SWITCH_ADDR = DEF_SWITCH_ADDR
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire iad_regreq_t req_i,
	output logic [DW-1:0] rdata_o,
	input wire logic [DW-1:0] ba_i,
	input wire logic ba_valid_i,
	input wire logic [DW-1:0] d_i,
	input wire iad_selsrc_t sel_src_i,
	input wire logic [SELW-1:0] rif_i,
	input wire logic [DW-1:0] instruction_word_latch_i,
	input wire logic [DW-1:0] result_mux_i,
	input wire logic scratch_we_i,
	input wire logic scratch_rd_en_i,
	input wire logic [DW-1:0] proc_status_word_i,
	input wire logic status_rd_en_i,
	input wire logic byte_op_i,
	input wire logic [DW-1:0] console_switches_i,
	input wire logic switch_to_bus_gate_i,
	input wire logic [UAW-1:0] buffered_next_uaddr_i,
	input wire logic cycle_end_i,
	output iad_hits_t hits_o,
	output logic ssyn_seq_o,
	output logic status_load_en_o,
	output logic ubranch_reservice_o,
	output logic console_branch_o,
	output logic test_ba_low_zero_o,
	output logic ba_seg_ones_n_o,
	output logic test_ba_top_ones_n_o,
	output logic red_zone_stop_o,
	output logic yellow_zone_flag_o,
	output logic word_zero_o,
	output logic nibble_zero_o,
	output logic [SELW-1:0] scratch_sel_lines_n_o,
	output logic sp_pc_select_detect_o,
	output logic incr_by_two_o,
	output logic stack_check_en_o,
	output logic [DW-1:0] reg_read_bus_o,
	output logic [DW-1:0] bus_data_o,
	output logic bus_data_oe_n_o,
	output logic uaddr_match_level_o,
	output logic scope_pulse_o
);
	if (DW != 16 || UAW > DW) begin : g_chk
		$error("iad_decode: unsupported widths");
	end

	logic [DW-1:0] ctrl_reg;
	logic [DW-1:0] ylim_reg;
	logic [DW-1:0] rlim_reg;
	logic [DW-1:0] sw_s1_reg, sw_s2_reg, sw_s3_reg, sw_reg;
	logic [SELW-1:0] sel_next;
	logic [DW-1:0] scratch_rdata;
	logic sp_pc_next;
	logic stack_ptr_next;
	iad_hits_t hits_next;
	logic match_next;

	// decode only from the internal latch: peripherals never see these addresses
	always_comb begin
		hits_next.status_word = ba_valid_i && ba_i == STATUS_ADDR;
		hits_next.stack_limit = ba_valid_i && ba_i == LIMIT_ADDR
			&& ctrl_reg[CTRL_LIMIT_EN];
		hits_next.scratch = ba_valid_i && (ba_i & SCRATCH_MASK) == SCRATCH_BASE;
		hits_next.switches = ba_valid_i && ba_i == SWITCH_ADDR;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hits_o <= '0;
			ssyn_seq_o <= 1'b0;
			status_load_en_o <= 1'b0;
			ubranch_reservice_o <= 1'b0;
			console_branch_o <= 1'b0;
		end else begin
			hits_o <= hits_next;
			ssyn_seq_o <= |hits_next;
			status_load_en_o <= hits_next.status_word;
			ubranch_reservice_o <= hits_next.status_word;
			console_branch_o <= hits_next.scratch;
		end
	end

	// address latch test terms
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			test_ba_low_zero_o <= 1'b0;
			ba_seg_ones_n_o <= 1'b1;
			test_ba_top_ones_n_o <= 1'b1;
		end else begin
			test_ba_low_zero_o <= ~|ba_i[BA_TEST_HI:BA_TEST_LO];
			ba_seg_ones_n_o <= ~&ba_i[BA_SEG_HI:BA_SEG_LO];
			// content check only, independent of ba_valid_i
			test_ba_top_ones_n_o <= ~&ba_i[BA_TOP_HI:BA_TOP_LO];
		end
	end

	// stack overflow zones judged on the absolute address of a stack pointer reference
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			red_zone_stop_o <= 1'b0;
			yellow_zone_flag_o <= 1'b0;
		end else begin
			red_zone_stop_o <= stack_check_en_o && ba_valid_i && ba_i < rlim_reg;
			// red takes precedence: a stop makes the trap moot
			yellow_zone_flag_o <= stack_check_en_o && ba_valid_i && ba_i >= rlim_reg
				&& ba_i < ylim_reg;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			word_zero_o <= 1'b0;
			nibble_zero_o <= 1'b0;
		end else begin
			word_zero_o <= ~|d_i;
			nibble_zero_o <= ~|d_i[D_NIB_HI:0];
		end
	end

	// scratch register selection
	always_comb begin
		case (sel_src_i)
			SRC_IMMEDIATE: sel_next = rif_i;
			SRC_INSTR_SRC: sel_next = {1'b0, instruction_word_latch_i[8:6]};
			SRC_INSTR_DST: sel_next = {1'b0, instruction_word_latch_i[2:0]};
			SRC_BUS_ADDR: sel_next = ba_i[SELW-1:0];
			default: sel_next = rif_i;
		endcase
	end

	assign sp_pc_next = &sel_next[2:1];
	assign stack_ptr_next = sp_pc_next && !sel_next[0];

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			scratch_sel_lines_n_o <= '1;
			sp_pc_select_detect_o <= 1'b0;
			incr_by_two_o <= 1'b0;
			stack_check_en_o <= 1'b0;
		end else begin
			scratch_sel_lines_n_o <= ~sel_next;
			sp_pc_select_detect_o <= sp_pc_next;
			incr_by_two_o <= sp_pc_next && byte_op_i;
			stack_check_en_o <= stack_ptr_next && ctrl_reg[CTRL_CHECK_EN];
		end
	end

	// storage follows the registered select lines so read and write never race
	iad_scratch #(
		.WIDTH(DW),
		.AW(SELW)
	) u_scratch (
		.clk_i(clk_i),
		.sel_lines_n_i(scratch_sel_lines_n_o),
		.we_i(scratch_we_i),
		.wdata_i(result_mux_i),
		.rdata_o(scratch_rdata)
	);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reg_read_bus_o <= '0;
		end else begin
			// wired-OR: every enabled source contributes
			reg_read_bus_o <= (scratch_rd_en_i ? scratch_rdata : '0)
				| (status_rd_en_i ? proc_status_word_i : '0);
		end
	end

	// console switches arrive from a pin: three stages, accept when stages two and three agree
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sw_s1_reg <= '0;
			sw_s2_reg <= '0;
			sw_s3_reg <= '0;
			sw_reg <= '0;
		end else begin
			sw_s1_reg <= console_switches_i;
			sw_s2_reg <= sw_s1_reg;
			sw_s3_reg <= sw_s2_reg;
			for (int i = 0; i < DW; i++) begin
				if (sw_s2_reg[i] == sw_s3_reg[i]) begin
					sw_reg[i] <= sw_s3_reg[i];
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bus_data_o <= '0;
			bus_data_oe_n_o <= 1'b1;
		end else begin
			bus_data_o <= switch_to_bus_gate_i ? sw_reg : '0;
			bus_data_oe_n_o <= !switch_to_bus_gate_i;
		end
	end

	// next address is taken as delivered; only a microjam upstream may alter it
	assign match_next = sw_reg[UAW-1:0] == buffered_next_uaddr_i;

	// halt use is valid only where the prior word ran a long cycle
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			uaddr_match_level_o <= 1'b0;
			scope_pulse_o <= 1'b0;
		end else begin
			uaddr_match_level_o <= match_next;
			scope_pulse_o <= cycle_end_i && match_next;
		end
	end

	// register port
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl_reg <= CTRL_RESET;
			ylim_reg <= YLIM_RESET;
			rlim_reg <= RLIM_RESET;
		end else if (req_i.we) begin
			if (req_i.addr == REG_CTRL) begin
				ctrl_reg <= req_i.wdata & 16'h0003;
			end else if (req_i.addr == REG_YLIM) begin
				ylim_reg <= req_i.wdata;
			end else if (req_i.addr == REG_RLIM) begin
				rlim_reg <= req_i.wdata;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= '0;
		end else if (req_i.re) begin
			if (req_i.addr == REG_CTRL) begin
				rdata_o <= ctrl_reg;
			end else if (req_i.addr == REG_STAT) begin
				rdata_o <= {5'h00, uaddr_match_level_o, nibble_zero_o, word_zero_o,
					yellow_zone_flag_o, red_zone_stop_o, stack_check_en_o,
					ssyn_seq_o, hits_o};
			end else if (req_i.addr == REG_YLIM) begin
				rdata_o <= ylim_reg;
			end else if (req_i.addr == REG_RLIM) begin
				rdata_o <= rlim_reg;
			end else begin
				rdata_o <= '0;
			end
		end else begin
			rdata_o <= '0;
		end
	end

	// checks
	sequence s_status_access;
		ba_valid_i && ba_i == STATUS_ADDR;
	endsequence

	sequence s_ack_with_load;
		ssyn_seq_o && status_load_en_o && ubranch_reservice_o;
	endsequence

	a_status_ack:
	assert property (@(posedge clk_i) disable iff (!rstn_i) s_status_access |=> s_ack_with_load)
	else $error("status access not acknowledged");

	a_reservice_cause:
	assert property (@(posedge clk_i) disable iff (!rstn_i)
		ubranch_reservice_o |-> $past(ba_valid_i) && $past(ba_i) == STATUS_ADDR)
	else $error("reservice without status access");

	a_limit_gated:
	assert property (@(posedge clk_i) disable iff (!rstn_i)
		!ctrl_reg[CTRL_LIMIT_EN] |=> !hits_o.stack_limit)
	else $error("stack limit decoded while disabled");

	a_switch_ack:
	assert property (@(posedge clk_i) disable iff (!rstn_i)
		hits_o.switches |-> ssyn_seq_o && !hits_o.status_word)
	else $error("switch hit without acknowledge");

	a_low_zero_test:
	assert property (@(posedge clk_i) disable iff (!rstn_i)
		ba_i[BA_TEST_HI:BA_TEST_LO] == 4'h0 |=> test_ba_low_zero_o)
	else $error("address low test term wrong");

	a_word_zero:
	assert property (@(posedge clk_i) disable iff (!rstn_i)
		word_zero_o |-> $past(d_i) == 16'h0000 && nibble_zero_o)
	else $error("word zero without zero data");

	a_red_stop:
	assert property (@(posedge clk_i) disable iff (!rstn_i)
		red_zone_stop_o |-> !yellow_zone_flag_o && $past(stack_check_en_o))
	else $error("red zone stop without check");

	a_sel_complement:
	assert property (@(posedge clk_i) disable iff (!rstn_i)
		sel_src_i == SRC_BUS_ADDR |=> scratch_sel_lines_n_o == ~$past(ba_i[SELW-1:0]))
	else $error("bus address selection wrong");

	a_byte_incr:
	assert property (@(posedge clk_i) disable iff (!rstn_i)
		incr_by_two_o |-> sp_pc_select_detect_o && &(~scratch_sel_lines_n_o[2:1]))
	else $error("increment by two without reg 6/7");

	a_switch_drive:
	assert property (@(posedge clk_i) disable iff (!rstn_i)
		switch_to_bus_gate_i |=> !bus_data_oe_n_o && bus_data_o == $past(sw_reg))
	else $error("switches not driven");

	a_scope_pulse:
	assert property (@(posedge clk_i) disable iff (!rstn_i)
		scope_pulse_o |-> uaddr_match_level_o && $past(cycle_end_i))
	else $error("scope pulse without match");
endmodule // iad_decode

//--- rtl/iad_scratch.sv
`timescale 1ns/1ps
module iad_scratch import iad_pkg::*; #(
	parameter int WIDTH = DW,
	parameter int AW = SELW
) (
	input wire logic clk_i,
	input wire logic [AW-1:0] sel_lines_n_i,
	input wire logic we_i,
	input wire logic [WIDTH-1:0] wdata_i,
	output logic [WIDTH-1:0] rdata_o
);
	localparam int DEPTH = 1 << AW;

	if (AW < 1 || WIDTH < 1) begin : g_chk
		$error("iad_scratch: bad geometry");
	end

	// contents are never cleared, like the original latch array
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] idx;

	// storage sees the complemented selection lines
	assign idx = ~sel_lines_n_i;
	assign rdata_o = mem_reg[idx];

	for (genvar i = 0; i < DEPTH; i++) begin : g_word
		always_ff @(posedge clk_i) begin
			if (we_i && idx == AW'(i)) begin
				mem_reg[i] <= wdata_i;
			end
		end
	end
endmodule // iad_scratch

//--- testbench/iad_console_model.sv
`timescale 1ns/1ps
module iad_console_model (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [8:0] target_i,
	output logic [15:0] console_switches_o,
	output logic [8:0] next_uaddr_o,
	output logic cycle_end_o
);
	logic [1:0] phase_reg;
	// every machine cycle runs three clocks long, so any target is a legal halt point
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			phase_reg <= 2'h0;
			next_uaddr_o <= 9'h000;
		end else begin
			phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
			if (phase_reg == 2'h2) begin
				next_uaddr_o <= next_uaddr_o + 9'h001;
			end
		end
	end
	assign cycle_end_o = (phase_reg == 2'h2);
	// upper switches carry a fixed pattern so the match cannot lean on them
	assign console_switches_o = {7'h55, target_i};
endmodule // iad_console_model

//--- testbench/internal_address_decode_and_match_test.sv
`timescale 1ns/1ps
module internal_address_decode_and_match_test;
	import iad_pkg::*;
	logic clk_i, rstn_i, ba_valid_i, scratch_we_i, scratch_rd_en_i, status_rd_en_i, byte_op_i;
	logic switch_to_bus_gate_i, cycle_end_i, ssyn_seq_o, status_load_en_o, ubranch_reservice_o;
	logic console_branch_o, test_ba_low_zero_o, ba_seg_ones_n_o, test_ba_top_ones_n_o;
	logic red_zone_stop_o, yellow_zone_flag_o, word_zero_o, nibble_zero_o, sp_pc_select_detect_o;
	logic incr_by_two_o, stack_check_en_o, bus_data_oe_n_o, uaddr_match_level_o, scope_pulse_o;
	logic [DW-1:0] rdata_o, ba_i, d_i, instruction_word_latch_i, result_mux_i, proc_status_word_i;
	logic [DW-1:0] console_switches_i, reg_read_bus_o, bus_data_o;
	logic [SELW-1:0] rif_i, scratch_sel_lines_n_o;
	logic [UAW-1:0] buffered_next_uaddr_i;
	logic [8:0] target;
	iad_regreq_t req_i;
	iad_selsrc_t sel_src_i;
	iad_hits_t hits_o;
	int errors, check_count;
	logic [15:0] v;

	iad_decode dut (.clk_i, .rstn_i, .req_i, .rdata_o, .ba_i, .ba_valid_i, .d_i, .sel_src_i,
		.rif_i, .instruction_word_latch_i, .result_mux_i, .scratch_we_i, .scratch_rd_en_i,
		.proc_status_word_i, .status_rd_en_i, .byte_op_i, .console_switches_i,
		.switch_to_bus_gate_i, .buffered_next_uaddr_i, .cycle_end_i, .hits_o, .ssyn_seq_o,
		.status_load_en_o, .ubranch_reservice_o, .console_branch_o, .test_ba_low_zero_o,
		.ba_seg_ones_n_o, .test_ba_top_ones_n_o, .red_zone_stop_o, .yellow_zone_flag_o,
		.word_zero_o, .nibble_zero_o, .scratch_sel_lines_n_o, .sp_pc_select_detect_o,
		.incr_by_two_o, .stack_check_en_o, .reg_read_bus_o, .bus_data_o, .bus_data_oe_n_o,
		.uaddr_match_level_o, .scope_pulse_o);
	iad_console_model con (.clk_i, .rstn_i, .target_i(target),
		.console_switches_o(console_switches_i), .next_uaddr_o(buffered_next_uaddr_i),
		.cycle_end_o(cycle_end_i));

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] dat);
		@(posedge clk_i);
		req_i <= '{addr: a, wdata: dat, we: 1'b1, re: 1'b0};
		@(posedge clk_i);
		req_i.we <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] dat);
		@(posedge clk_i);
		req_i <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
		@(posedge clk_i);
		req_i.re <= 1'b0;
		#1 dat = rdata_o;
	endtask

	// inputs hold, so a few edges cover the one-cycle latency plus the zone stage
	task automatic settle;
		repeat (3) @(posedge clk_i);
		#1;
	endtask

	task automatic t_hits;
		logic [15:0] a[6] = '{16'hFFFE, 16'hFFFA, 16'hFFC5, 16'hFF78, 16'h1234, 16'hFFFA};
		logic [7:0] e[6] = '{8'h8E, 8'h00, 8'h29, 8'h18, 8'h00, 8'h48};
		rd(REG_CTRL, v);
		chk("ctrl reset", 16'h0002, v);
		rd(4'h2, v);
		chk("unmapped", 16'h0000, v);
		rd(REG_YLIM, v);
		chk("ylim reset", 16'h0100, v);
		rd(REG_RLIM, v);
		chk("rlim reset", 16'h00E0, v);
		for (int i = 0; i < 6; i++) begin
			if (i == 5) begin
				wr(REG_CTRL, 16'hFFFF);
				rd(REG_CTRL, v);
				chk("ctrl mask", 16'h0003, v);
			end
			@(posedge clk_i);
			ba_i <= a[i];
			ba_valid_i <= 1'b1;
			settle();
			chk("hits", {8'h00, e[i]}, {8'h00, hits_o, ssyn_seq_o, status_load_en_o,
				ubranch_reservice_o, console_branch_o});
		end
		@(posedge clk_i);
		ba_i <= 16'hFFFE;
		ba_valid_i <= 1'b0;
		settle();
		chk("dead latch", 16'h0000, {15'h0000, ssyn_seq_o});
		$display("test hits done");
	endtask

	task automatic t_bits;
		logic [15:0] a[3] = '{16'h0000, 16'hFF87, 16'h00E8};
		logic [15:0] d[3] = '{16'h0000, 16'hFF80, 16'h00E8};
		logic [2:0] e[3] = '{3'h7, 3'h6, 3'h1};
		logic [1:0] z[3] = '{2'h3, 2'h1, 2'h0};
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_i);
			ba_i <= a[i];
			ba_valid_i <= 1'b1;
			d_i <= d[i];
			settle();
			chk("ba tests", {13'h0000, e[i]}, {13'h0000, test_ba_low_zero_o, ba_seg_ones_n_o,
				test_ba_top_ones_n_o});
			chk("zeros", {14'h0000, z[i]},
				{14'h0000, word_zero_o, nibble_zero_o});
		end
		$display("test bits done");
	endtask

	task automatic t_select;
		iad_selsrc_t s[4] = '{SRC_IMMEDIATE, SRC_INSTR_SRC, SRC_INSTR_DST, SRC_BUS_ADDR};
		logic [6:0] e[4] = '{7'h0F, 7'h4F, 7'h50, 7'h46};
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			sel_src_i <= s[i];
			rif_i <= 4'hE;
			instruction_word_latch_i <= 16'h0185;
			ba_i <= 16'hFFC7;
			byte_op_i <= 1'b1;
			settle();
			chk("select", {9'h000, e[i]}, {9'h000, scratch_sel_lines_n_o, sp_pc_select_detect_o,
				incr_by_two_o, stack_check_en_o});
		end
		$display("test select done");
	endtask

	task automatic t_zones;
		logic [15:0] a[4] = '{16'h0010, 16'h00F0, 16'h0200, 16'h0010};
		logic [1:0] e[4] = '{2'h2, 2'h1, 2'h0, 2'h0};
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			sel_src_i <= SRC_IMMEDIATE;
			rif_i <= (i == 3) ? 4'h7 : 4'h6;
			ba_i <= a[i];
			ba_valid_i <= 1'b1;
			settle();
			chk("zones", {14'h0000, e[i]},
				{14'h0000, red_zone_stop_o, yellow_zone_flag_o});
			if (i == 0) begin
				// match bit follows the free-running microaddress, so it is left out
				rd(REG_STAT, v);
				chk("stat", 16'h0060, v & 16'hFBFF);
			end
		end
		wr(REG_RLIM, 16'h0030);
		rd(REG_RLIM, v);
		chk("rlim write", 16'h0030, v);
		$display("test zones done");
	endtask

	task automatic t_scratch;
		logic [3:0] r[2] = '{4'h3, 4'h5};
		logic [15:0] w[2] = '{16'hA5C3, 16'h0F0F};
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_i);
			rif_i <= r[i];
			result_mux_i <= w[i];
			settle();
			@(posedge clk_i);
			scratch_we_i <= 1'b1;
			@(posedge clk_i);
			scratch_we_i <= 1'b0;
		end
		rif_i <= 4'h3;
		scratch_rd_en_i <= 1'b1;
		settle();
		chk("scratch read", 16'hA5C3, reg_read_bus_o);
		@(posedge clk_i);
		proc_status_word_i <= 16'h1200;
		status_rd_en_i <= 1'b1;
		settle();
		chk("wired or", 16'hB7C3, reg_read_bus_o);
		$display("test scratch done");
	endtask

	task automatic t_console;
		int n;
		@(posedge clk_i);
		switch_to_bus_gate_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		#1 chk("switch bus", {7'h55, target}, bus_data_o);
		chk("drive low", 16'h0000, {15'h0000, bus_data_oe_n_o});
		@(posedge clk_i);
		switch_to_bus_gate_i <= 1'b0;
		settle();
		chk("released", 16'h0001, {15'h0000, bus_data_oe_n_o});
		for (n = 0; n < 3000 && scope_pulse_o !== 1'b1; n++) begin
			@(posedge clk_i);
			#1;
		end
		if (n == 3000) begin
			errors++;
			$display("Error scope pulse expected 1 seen 0");
		end else begin
			chk("match", 16'h0001, {15'h0000, uaddr_match_level_o});
			chk("next addr", {7'h00, target + 9'h001}, {7'h00, buffered_next_uaddr_i});
			@(posedge clk_i);
			#1;
			chk("pulse ends", 16'h0000, {15'h0000, scope_pulse_o});
		end
		$display("test console done");
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		{ba_valid_i, scratch_we_i, scratch_rd_en_i, status_rd_en_i, byte_op_i} = '0;
		{switch_to_bus_gate_i, ba_i, d_i, instruction_word_latch_i, result_mux_i} = '0;
		proc_status_word_i = '0;
		rif_i = '0;
		req_i = '0;
		sel_src_i = SRC_IMMEDIATE;
		target = 9'h012;
		errors = 0;
		check_count = 0;
		rstn_i = 1'b0;
		repeat (8) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_hits();
		t_bits();
		t_select();
		t_zones();
		t_scratch();
		t_console();
		close_out();
	end
endmodule // internal_address_decode_and_match_test
